// [include/dadc_pkg.sv]
package dadc_pkg;
    // ==========================================================
    // Serial register map
    localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
    localparam logic [12:0] ADDR_CHAN_SEL = 13'h0005;
    localparam logic [12:0] ADDR_POWER    = 13'h0008;
    localparam logic [12:0] ADDR_CLK_DIV  = 13'h000B;
    localparam logic [12:0] ADDR_OUT_MODE = 13'h0014;
    localparam logic [12:0] ADDR_SYNC_CTL = 13'h003A;
    localparam logic [12:0] ADDR_STATUS   = 13'h003B;
    // ==========================================================
    // Field positions
    localparam int BIT_LSB_FIRST   = 6;
    localparam int BIT_OUT_TRI     = 4;
    localparam int BIT_SYNC_EN     = 1;
    localparam int BIT_SYNC_ONCE   = 2;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_PORT_CFG = 8'h00;
    localparam logic [1:0] RST_CHAN_SEL = 2'h3;
    localparam logic [1:0] RST_POWER    = 2'h0;
    localparam logic [2:0] RST_CLK_DIV  = 3'h0;
    localparam logic [7:0] RST_OUT_MODE = 8'h01;
    localparam logic [7:0] RST_SYNC_CTL = 8'h00;
    // ==========================================================
    // Counts
    localparam int INSTR_BITS      = 16;
    localparam int PIPE_LATENCY    = 10;
    localparam int SEL_IDLE_CYCLES = 16;
    localparam int FIFO_DEPTH      = 8;
    // ==========================================================
    // Modes and sample pair
    typedef enum logic [1:0] {
        FMT_OFFSET_BIN = 2'h0,
        FMT_TWOS_COMP  = 2'h1,
        FMT_GRAY       = 2'h2
    } dadc_fmt_t;
    typedef enum logic [1:0] {
        PWR_NORMAL  = 2'h0,
        PWR_DOWN    = 2'h1,
        PWR_STANDBY = 2'h2
    } dadc_pwr_t;
    typedef struct packed {
        logic [11:0] a_code;
        logic        a_or;
        logic [11:0] b_code;
        logic        b_or;
    } dadc_pair_t;
endpackage : dadc_pkg

// [rtl/dadc_ctrl.sv]
`timescale 1ns/10ps
// ==========================================================
// Sample FIFO
module dadc_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rstn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    always_ff @(posedge mclk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : dadc_fifo

// ==========================================================
// Converter digital control
// Contract
// - Pin or register request enters power-down
// - Power-down floats all data drivers
// - Pin low returns to normal operation
// - Register standby keeps reference powered
// - Encoding selectable: offset, twos, gray
// - Twos complement default; saturate out-of-range
// - Three-state pin high floats data
// - Per-channel three-state bit 4, 0x14
// - One channel off: repeat other channel
// - Ten sample clock pipeline latency
// - Data capture clock driven with data
// - Over-range flag aligned, ten cycles
// - Strobe resync once or always, 0x3A
// - Alignment strobe synchronised before use
// - Select fall plus clock starts frame
// - Select low streams; high stalls bytes (code: high ends a streaming-length frame)
// - Select held high floats port pins
// - Sixteen-bit instruction: direction and length
// - Eight-bit data; first bit is direction (code: last bit in LSB-first mode)
// - Read turns data line at data phase
// - MSB first default; LSB first selectable
// - Valid strobe resets divider; bits 1, 2
// - Divider ratio programmable one to eight
module dadc_ctrl
    import dadc_pkg::*;
#(
    parameter int RAW_W = 14
) (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rstn,
    // Converter core samples, sample enable and power enables
    input  wire logic signed [RAW_W-1:0] adc_a_raw,
    input  wire logic signed [RAW_W-1:0] adc_b_raw,
    output logic                         sample_en_q,
    output logic                         core_power_en_q,
    output logic                         ref_power_en_q,
    // Control pins
    input  wire logic                    power_down_request,
    input  wire logic                    output_three_state_n,
    input  wire logic                    align_strobe,
    // Data output port
    output logic             [11:0]      data_out_q,
    output logic                         over_range_q,
    output logic                         data_oe_n_q,
    output logic                         data_capture_clock_out_q,
    // Serial port
    input  wire logic                    sclk,
    input  wire logic                    port_select_n,
    input  wire logic                    sdio_in,
    output logic                         sdio_out_q,
    output logic                         sdio_oe_n_q,
    output logic                         secondary_en_q
);
    // ==========================================================
    // Pin synchronisers
    logic [1:0] pd_s_q, oe_s_q, st_s_q, ck_s_q, cs_s_q, di_s_q;
    logic       st_d_q, ck_d_q, cs_d_q;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pd_s_q <= '0;
            oe_s_q <= 2'h3;
            st_s_q <= '0;
            ck_s_q <= '0;
            cs_s_q <= 2'h3;
            di_s_q <= '0;
            st_d_q <= 1'b0;
            ck_d_q <= 1'b0;
            cs_d_q <= 1'b1;
        end
        else
        begin
            pd_s_q <= {pd_s_q[0], power_down_request};
            oe_s_q <= {oe_s_q[0], output_three_state_n};
            st_s_q <= {st_s_q[0], align_strobe};
            ck_s_q <= {ck_s_q[0], sclk};
            cs_s_q <= {cs_s_q[0], port_select_n};
            di_s_q <= {di_s_q[0], sdio_in};
            st_d_q <= st_s_q[1];
            ck_d_q <= ck_s_q[1];
            cs_d_q <= cs_s_q[1];
        end
    end
    wire strobe_rise = st_s_q[1] && !st_d_q;
    wire sck_rise    = ck_s_q[1] && !ck_d_q;
    wire sck_fall    = !ck_s_q[1] && ck_d_q;
    wire sel         = !cs_s_q[1];
    wire sel_fall    = sel && cs_d_q;
    wire sel_rise    = !sel && !cs_d_q;

    // ==========================================================
    // Registers
    logic [7:0] port_cfg_q, out_mode_a_q, out_mode_b_q, sync_ctl_q;
    logic [1:0] chan_sel_q, power_q;
    logic [2:0] clk_div_q;
    logic       sync_armed_q;
    logic       fifo_full;
    wire  lsb_first = port_cfg_q[BIT_LSB_FIRST];
    wire  pd_active = pd_s_q[1] || (power_q == PWR_DOWN);
    wire  sb_active = !pd_active && (power_q == PWR_STANDBY);

    function automatic logic [7:0] reg_read(input logic [12:0] a);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            ADDR_PORT_CFG: r = port_cfg_q;
            ADDR_CHAN_SEL: r = {6'h00, chan_sel_q};
            ADDR_POWER:    r = {6'h00, power_q};
            ADDR_CLK_DIV:  r = {5'h00, clk_div_q};
            ADDR_OUT_MODE: r = chan_sel_q[0] ? out_mode_a_q : out_mode_b_q;
            ADDR_SYNC_CTL: r = sync_ctl_q;
            ADDR_STATUS:   r = {4'h0, fifo_full, sync_armed_q, sb_active, pd_active};
            default:       r = 8'h00;
        endcase
        return r;
    endfunction : reg_read

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++)
            r[i] = v[7-i];
        return r;
    endfunction : rev8

    // ==========================================================
    // Serial frame engine
    typedef enum logic [1:0] {SP_IDLE, SP_INSTR, SP_DATA, SP_DONE} dadc_sp_t;
    dadc_sp_t    sp_q;
    logic [15:0] shin_q;
    logic [4:0]  bit_q;
    logic [12:0] addr_q;
    logic        rd_q;
    logic [1:0]  len_q;
    logic [1:0]  bytes_q;
    logic [7:0]  tx_q;
    logic [4:0]  idle_q;
    wire  [15:0] shin_nx   = {shin_q[14:0], di_s_q[1]};
    // Whole instruction is bit-reversed in LSB-first mode
    wire  [15:0] instr     = lsb_first ? {rev8(shin_nx[7:0]), rev8(shin_nx[15:8])} : shin_nx;
    wire  [7:0]  byte_in   = lsb_first ? rev8(shin_nx[7:0]) : shin_nx[7:0];
    wire         byte_end  = (bit_q[2:0] == 3'h7);
    wire         instr_end = (bit_q == 5'(INSTR_BITS - 1));
    wire  [12:0] addr_nx   = lsb_first ? addr_q + 13'h1 : addr_q - 13'h1;
    wire         last_byte = (len_q != 2'h3) && (bytes_q == len_q);
    wire         wr_strobe = (sp_q == SP_DATA) && sel && sck_rise && byte_end && !rd_q;
    // Stall: outside streaming length (len 3), select may rise on a byte boundary without ending the frame
    wire         stall_ok  = (bit_q[2:0] == 3'h0) && (sp_q == SP_INSTR && bit_q != '0
                             || sp_q == SP_DATA && len_q != 2'h3);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sp_q    <= SP_IDLE;
            shin_q  <= '0;
            bit_q   <= '0;
            addr_q  <= '0;
            rd_q    <= 1'b0;
            len_q   <= '0;
            bytes_q <= '0;
            tx_q    <= '0;
        end
        else if (sel_fall && !(stall_ok && sp_q != SP_IDLE))
        begin
            sp_q  <= SP_INSTR;
            bit_q <= '0;
        end
        else if (sel_rise && !stall_ok)
            sp_q <= SP_IDLE;
        else if (sel && sck_rise)
        begin
            shin_q <= shin_nx;
            unique case (sp_q)
                SP_INSTR:
                begin
                    bit_q <= bit_q + 5'h1;
                    if (instr_end)
                    begin
                        rd_q    <= instr[15];
                        len_q   <= instr[14:13];
                        addr_q  <= instr[12:0];
                        tx_q    <= reg_read(instr[12:0]);
                        bytes_q <= '0;
                        bit_q   <= '0;
                        sp_q    <= SP_DATA;
                    end
                end
                SP_DATA:
                begin
                    bit_q <= bit_q + 5'h1;
                    if (byte_end)
                    begin
                        addr_q  <= addr_nx;
                        tx_q    <= reg_read(addr_nx);
                        bytes_q <= (bytes_q == 2'h3) ? 2'h3 : bytes_q + 2'h1;
                        bit_q   <= '0;
                        if (last_byte)
                            sp_q <= SP_DONE;
                    end
                end
                default: ;
            endcase
        end
        else if (sel && sck_fall && sp_q == SP_DATA && rd_q)
            tx_q <= lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
    end

    // Read data leaves on falling edges once the data phase starts
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sdio_out_q     <= 1'b0;
            sdio_oe_n_q    <= 1'b1;
            idle_q         <= '0;
            secondary_en_q <= 1'b0;
        end
        else
        begin
            if (sel && sck_fall && sp_q == SP_DATA && rd_q)
                sdio_out_q <= lsb_first ? tx_q[0] : tx_q[7];
            sdio_oe_n_q <= !(sel && sp_q == SP_DATA && rd_q);
            if (sel)
                idle_q <= '0;
            else if (idle_q != 5'(SEL_IDLE_CYCLES))
                idle_q <= idle_q + 5'h1;
            secondary_en_q <= !sel && (idle_q == 5'(SEL_IDLE_CYCLES));
        end
    end

    // ==========================================================
    // Register writes
    wire [12:0] wa = addr_q;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            port_cfg_q   <= RST_PORT_CFG;
            chan_sel_q   <= RST_CHAN_SEL;
            power_q      <= RST_POWER;
            clk_div_q    <= RST_CLK_DIV;
            out_mode_a_q <= RST_OUT_MODE;
            out_mode_b_q <= RST_OUT_MODE;
            sync_ctl_q   <= RST_SYNC_CTL;
        end
        else if (wr_strobe)
        begin
            if (wa == ADDR_PORT_CFG)
                port_cfg_q <= byte_in;
            if (wa == ADDR_CHAN_SEL)
                chan_sel_q <= byte_in[1:0];
            if (wa == ADDR_POWER)
                power_q <= byte_in[1:0];
            if (wa == ADDR_CLK_DIV)
                clk_div_q <= byte_in[2:0];
            if (wa == ADDR_OUT_MODE && chan_sel_q[0])
                out_mode_a_q <= byte_in;
            if (wa == ADDR_OUT_MODE && chan_sel_q[1])
                out_mode_b_q <= byte_in;
            if (wa == ADDR_SYNC_CTL)
                sync_ctl_q <= byte_in;
        end
    end

    // ==========================================================
    // Divider with strobe resynchronisation
    logic [2:0] div_q;
    logic       stall;
    wire sync_hit = strobe_rise && sync_ctl_q[BIT_SYNC_EN]
                    && (!sync_ctl_q[BIT_SYNC_ONCE] || sync_armed_q);
    wire running  = !pd_active && !sb_active;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_q        <= '0;
            sync_armed_q <= 1'b0;
            sample_en_q  <= 1'b0;
        end
        else
        begin
            if (wr_strobe && wa == ADDR_SYNC_CTL)
                sync_armed_q <= 1'b1;
            else if (sync_hit)
                sync_armed_q <= 1'b0;
            if (sync_hit || div_q == clk_div_q)
                div_q <= '0;
            else
                div_q <= div_q + 3'h1;
            // A full FIFO drops the sample slot rather than corrupting latency
            sample_en_q <= running && !stall && !sync_hit && (div_q == clk_div_q);
        end
    end

    // ==========================================================
    // Saturation, encoding and pipeline
    function automatic logic [12:0] sat_code(input logic signed [RAW_W-1:0] r,
                                            input logic [1:0] fmt);
        logic [11:0] t;
        logic        o;
        o = (r > RAW_W'(2047)) || (r < -RAW_W'(2048));
        t = (r > RAW_W'(2047)) ? 12'h7FF : (r < -RAW_W'(2048)) ? 12'h800 : r[11:0];
        unique case (fmt)
            FMT_TWOS_COMP: return {t, o};
            FMT_GRAY:      return {{~t[11], t[10:0]} ^ {1'b0, ~t[11], t[10:1]}, o};
            default:       return {~t[11], t[10:0], o};
        endcase
    endfunction : sat_code

    dadc_pair_t pipe_q [PIPE_LATENCY];
    logic       pv_q [PIPE_LATENCY];
    wire [12:0] enc_a = sat_code(adc_a_raw, out_mode_a_q[1:0]);
    wire [12:0] enc_b = sat_code(adc_b_raw, out_mode_b_q[1:0]);
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < PIPE_LATENCY; i++)
            begin
                pipe_q[i] <= '0;
                pv_q[i]   <= 1'b0;
            end
        end
        else if (sample_en_q)
        begin
            pipe_q[0] <= {enc_a, enc_b};
            pv_q[0]   <= 1'b1;
            for (int i = 1; i < PIPE_LATENCY; i++)
            begin
                pipe_q[i] <= pipe_q[i-1];
                pv_q[i]   <= pv_q[i-1];
            end
        end
    end

    // ==========================================================
    // Output buffer and interleaver
    logic       in_ready, out_valid, phase_q;
    dadc_pair_t head;
    dadc_pair_t cur_q;
    assign stall     = !in_ready;
    assign fifo_full = !in_ready;
    dadc_fifo #(
        .WIDTH ($bits(dadc_pair_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_valid  (sample_en_q && pv_q[PIPE_LATENCY-1]),
        .in_ready  (in_ready),
        .in_data   (pipe_q[PIPE_LATENCY-1]),
        .out_valid (out_valid),
        .out_ready (!phase_q),
        .out_data  (head)
    );
    wire a_off  = out_mode_a_q[BIT_OUT_TRI];
    wire b_off  = out_mode_b_q[BIT_OUT_TRI];
    wire show_a = phase_q ? b_off : !a_off;
    wire [12:0] nxt = !phase_q ? (a_off ? {head.b_code, head.b_or} : {head.a_code, head.a_or})
                               : (show_a ? {cur_q.a_code, cur_q.a_or}
                                         : {cur_q.b_code, cur_q.b_or});
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_q                  <= 1'b0;
            cur_q                    <= '0;
            data_out_q               <= '0;
            over_range_q             <= 1'b0;
            data_oe_n_q              <= 1'b1;
            data_capture_clock_out_q <= 1'b0;
            core_power_en_q          <= 1'b1;
            ref_power_en_q           <= 1'b1;
        end
        else
        begin
            core_power_en_q <= running;
            ref_power_en_q  <= !pd_active;
            // Output and data clock hold at the B half, clock low, when the FIFO runs dry
            if (!phase_q && out_valid)
                cur_q <= head;
            if (phase_q || out_valid)
            begin
                phase_q                  <= !phase_q;
                data_capture_clock_out_q <= !phase_q;
                data_out_q               <= nxt[12:1];
                over_range_q             <= nxt[0];
            end
            data_oe_n_q <= pd_active || sb_active || oe_s_q[1]
                           || (a_off && b_off);
        end
    end
endmodule : dadc_ctrl

// [verif/dadc_host.sv]
`timescale 1ns/10ps
// ==========================================================
// Serial host model
module dadc_host (
    // Clock
    input  wire logic mclk,
    // Serial pins
    output logic      sclk,
    output logic      port_select_n,
    output logic      sdio_in,
    input  wire logic sdio_out_q,
    input  wire logic sdio_oe_n_q
);
    logic host_d  = 1'b0;
    logic host_oe = 1'b1;
    logic lsb     = 1'b0;
    // A released line shows the inverse of its last level, never a held value
    assign sdio_in = !sdio_oe_n_q ? sdio_out_q : (host_oe ? host_d : !host_d);
    initial
    begin
        sclk = 1'b0;
        port_select_n = 1'b1;
    end
    task automatic xfer(input logic rw, input logic [12:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        logic [15:0] ins;
        ins = {rw, 2'b00, a};
        q = 8'h00;
        @(negedge mclk);
        port_select_n = 1'b0;
        repeat (5) @(negedge mclk);
        for (int i = 0; i < 24; i++)
        begin
            sclk = 1'b0;
            host_oe = !(rw && i >= 16);
            if (i < 16)
                host_d = lsb ? ins[i] : ins[15-i];
            else
                host_d = lsb ? d[i-16] : d[23-i];
            repeat (5) @(negedge mclk);
            if (i >= 16)
                q[lsb ? i-16 : 23-i] = sdio_in;
            sclk = 1'b1;
            repeat (5) @(negedge mclk);
        end
        sclk = 1'b0;
        repeat (5) @(negedge mclk);
        port_select_n = 1'b1;
        host_oe = 1'b1;
        repeat (30) @(negedge mclk);
    endtask : xfer
endmodule : dadc_host

// [verif/dadc_properties.sv]
`timescale 1ns/10ps
// ==========================================================
// Port checker
module dadc_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Control pins
    input wire logic power_down_request,
    input wire logic output_three_state_n,
    input wire logic port_select_n,
    // Watched outputs
    input wire logic sample_en_q,
    input wire logic core_power_en_q,
    input wire logic ref_power_en_q,
    input wire logic data_oe_n_q,
    input wire logic data_capture_clock_out_q,
    input wire logic sdio_oe_n_q,
    input wire logic secondary_en_q
);
    logic [4:0] idle_q;
    logic [4:0] idle_d;
    // Saturates well past the idle threshold plus synchroniser delay
    assign idle_d = !port_select_n ? 5'h00 : (idle_q == 5'h1F ? idle_q : idle_q + 5'h01);
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            idle_q <= 5'h00;
        else
            idle_q <= idle_d;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    sequence pd_held;
        power_down_request [*4];
    endsequence
    sequence sel_held;
        port_select_n [*4];
    endsequence
    chk_pd_floats: assert property (pd_held |-> data_oe_n_q)
        else $error("data pins driven in power-down");
    chk_pd_powers: assert property (pd_held |-> !core_power_en_q && !ref_power_en_q)
        else $error("core or reference still powered in power-down");
    chk_pd_no_sample: assert property (pd_held |-> !sample_en_q)
        else $error("sample taken in power-down");
    chk_tri_floats: assert property (output_three_state_n [*4] |-> data_oe_n_q)
        else $error("data pins driven with three-state pin high");
    chk_ref_outlives: assert property (!ref_power_en_q |-> !core_power_en_q)
        else $error("core powered while reference is off");
    chk_idle_secondary: assert property (idle_q == 5'h1F |-> secondary_en_q)
        else $error("secondary functions not enabled while idle");
    chk_frame_clears: assert property (!port_select_n [*4] |-> !secondary_en_q)
        else $error("secondary functions active during a frame");
    chk_sel_gates: assert property (sel_held |-> sdio_oe_n_q)
        else $error("serial data driven while deselected");
    chk_dco_halves: assert property (data_capture_clock_out_q |=> !data_capture_clock_out_q)
        else $error("data clock high for two cycles");
endmodule : dadc_properties
bind dadc_ctrl dadc_properties u_chk (
    .mclk, .rstn, .power_down_request, .output_three_state_n, .port_select_n, .sample_en_q,
    .core_power_en_q, .ref_power_en_q, .data_oe_n_q, .data_capture_clock_out_q, .sdio_oe_n_q,
    .secondary_en_q
);

// [verif/tb_top.sv]
`timescale 1ns/10ps
// ==========================================================
// Converter control bench
module tb_top;
    import dadc_pkg::*;
    typedef struct packed {
        logic [1:0]  fmt;
        logic [13:0] raw;
        logic [11:0] code;
        logic        ovr;
    } dadc_row_t;
    // Format 0 offset, 1 twos complement, 2 gray
    dadc_row_t rows [8] = '{
        '{2'h1, 14'h3800, 12'h800, 1'b0}, '{2'h1, 14'h3448, 12'h800, 1'b1},
        '{2'h1, 14'h07FF, 12'h7FF, 1'b0}, '{2'h1, 14'h0000, 12'h000, 1'b0},
        '{2'h0, 14'h0000, 12'h800, 1'b0}, '{2'h0, 14'h1388, 12'hFFF, 1'b1},
        '{2'h0, 14'h3800, 12'h000, 1'b0}, '{2'h2, 14'h07FF, 12'h800, 1'b0}};
    logic               mclk = 1'b0;
    logic               rstn = 1'b0;
    logic signed [13:0] adc_a_raw = 14'h0000;
    logic signed [13:0] adc_b_raw = 14'h0100;
    logic               power_down_request = 1'b0;
    logic               output_three_state_n = 1'b0;
    logic               align_strobe = 1'b0;
    logic [11:0]        data_out_q, a_seen, b_seen;
    logic               sample_en_q, core_power_en_q, ref_power_en_q, over_range_q, or_seen;
    logic               data_oe_n_q, data_capture_clock_out_q, sdio_out_q, sdio_oe_n_q;
    logic               secondary_en_q;
    wire                sclk, port_select_n, sdio_in;
    logic [7:0]         rv;
    int                 err_count = 0, comparisons = 0, n;
    always #20 mclk = ~mclk;
    dadc_ctrl u_dut (
        .mclk, .rstn, .adc_a_raw, .adc_b_raw, .sample_en_q, .core_power_en_q, .ref_power_en_q,
        .power_down_request, .output_three_state_n, .align_strobe, .data_out_q, .over_range_q,
        .data_oe_n_q, .data_capture_clock_out_q, .sclk, .port_select_n, .sdio_in, .sdio_out_q,
        .sdio_oe_n_q, .secondary_en_q
    );
    dadc_host u_host (.mclk, .sclk, .port_select_n, .sdio_in, .sdio_out_q, .sdio_oe_n_q);
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        u_host.xfer(1'b0, a, d, rv);
    endtask : wr
    task automatic rd(input logic [12:0] a, input logic [7:0] e, input string w);
        u_host.xfer(1'b1, a, 8'h00, rv);
        chk({4'h0, rv}, {4'h0, e}, w);
    endtask : rd
    // Long settle: the full FIFO and pipeline hold stale samples
    task automatic look;
        repeat (80) @(negedge mclk);
        for (n = 0; n < 50 && data_capture_clock_out_q !== 1'b1; n++) @(negedge mclk);
        if (n == 50)
        begin
            err_count++;
            test_done();
        end
        a_seen = data_out_q;
        or_seen = over_range_q;
        @(negedge mclk);
        b_seen = data_out_q;
    endtask : look
    function automatic logic [11:0] pw;
        return {9'h000, data_oe_n_q, core_power_en_q, ref_power_en_q};
    endfunction : pw
    initial
    begin
        repeat (2) @(negedge mclk);
        rstn = 1'b1;
        repeat (4) @(negedge mclk);
        rd(ADDR_OUT_MODE, RST_OUT_MODE, "format reset");
        rd(ADDR_SYNC_CTL, RST_SYNC_CTL, "sync reset");
        rd(13'h007F, 8'h00, "unmapped read");
        chk(12'(secondary_en_q), 12'h001, "secondary");
        wr(ADDR_SYNC_CTL, 8'h06);
        rd(ADDR_SYNC_CTL, 8'h06, "sync readback");
        foreach (rows[i])
        begin
            wr(ADDR_OUT_MODE, {6'h00, rows[i].fmt});
            adc_a_raw = rows[i].raw;
            look();
            chk(a_seen, rows[i].code, "sample code");
            chk(12'(or_seen), 12'(rows[i].ovr), "over range");
        end
        wr(ADDR_OUT_MODE, 8'h01);
        adc_a_raw = 14'h0123;
        look();
        chk(b_seen, 12'h100, "B half");
        wr(ADDR_CHAN_SEL, 8'h02);
        wr(ADDR_OUT_MODE, 8'h11);
        look();
        chk(b_seen, 12'h123, "A repeated");
        chk(12'(data_oe_n_q), 12'h000, "one channel on");
        wr(ADDR_CHAN_SEL, 8'h01);
        wr(ADDR_OUT_MODE, 8'h11);
        chk(12'(data_oe_n_q), 12'h001, "both off");
        wr(ADDR_CHAN_SEL, 8'h03);
        wr(ADDR_OUT_MODE, 8'h01);
        power_down_request = 1'b1;
        repeat (6) @(negedge mclk);
        chk(pw(), 12'h004, "pin power-down");
        power_down_request = 1'b0;
        repeat (6) @(negedge mclk);
        chk(pw(), 12'h003, "wake");
        wr(ADDR_POWER, 8'h01);
        chk(pw(), 12'h004, "register power-down");
        wr(ADDR_POWER, 8'h02);
        chk(pw(), 12'h005, "standby");
        wr(ADDR_POWER, 8'h00);
        output_three_state_n = 1'b1;
        repeat (4) @(negedge mclk);
        chk(12'(data_oe_n_q), 12'h001, "three-state pin");
        output_three_state_n = 1'b0;
        // Ratio 4 drains the FIFO, so only the pipeline adds latency
        wr(ADDR_CLK_DIV, 8'h03);
        look();
        adc_a_raw = 14'h0456;
        n = 0;
        for (int k = 0; k < 100 && (data_out_q !== 12'h456 || !data_capture_clock_out_q); k++)
        begin
            @(negedge mclk);
            n += sample_en_q;
        end
        chk(12'(n >= 10 && n <= 12), 12'h001, "latency");
        wr(ADDR_PORT_CFG, 8'h40);
        u_host.lsb = 1'b1;
        rd(ADDR_PORT_CFG, 8'h40, "lsb first config");
        rd(ADDR_CLK_DIV, 8'h03, "lsb first divider");
        wr(ADDR_PORT_CFG, 8'h00);
        u_host.lsb = 1'b0;
        rd(ADDR_CLK_DIV, 8'h03, "msb first again");
        wr(ADDR_SYNC_CTL, 8'h06);
        rd(ADDR_STATUS, 8'h04, "sync armed");
        align_strobe = 1'b1;
        repeat (4) @(negedge mclk);
        align_strobe = 1'b0;
        rd(ADDR_STATUS, 8'h00, "sync taken");
        test_done();
    end
endmodule : tb_top
